// file: core/pwr_mode_pkg.sv
package pwr_mode_pkg;

  // Pin pulse must stay active this many clocks to count
  localparam logic [3:0] QUAL_LEN = 4'h8;
  // Rising edges of the new oscillator before its gate opens
  localparam logic [1:0] SWITCH_EDGES = 2'h2;
  // Last hold count; the system reset output is held this many clocks plus one
  localparam logic [2:0] RESET_HOLD = 3'h4;
  // Program counter restart address
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // Field positions in the power and slow oscillator control regs
  localparam int IDLE_POS = 0;
  localparam int STOP_POS = 1;
  localparam int CMODE_POS = 0;
  localparam logic [1:0] POWER_CONTROL_REG_RESET = 2'h0;
  localparam logic CMODE_RESET = 1'b0;

  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_IDLE,
    MODE_STOP,
    MODE_RESET
  } pmode_t;

  // Requests from the processor core, same clock
  typedef struct packed {
    logic inst_done;
    logic power_control_reg_wr;
    logic [1:0] power_control_reg_wdata;
    logic xcon_wr;
    logic xcon_wdata;
    logic return_from_interrupt;
    logic periph_irq;
  } core_req_t;

  // External interrupt setup from timer control and enable regs
  typedef struct packed {
    logic [1:0] trigger_type;
    logic [1:0] irq_enable;
    logic global_enable;
    logic [1:0] irq_ack;
  } ext_cfg_t;

  // State of one pin qualifier
  typedef struct packed {
    logic s1;
    logic s2;
    logic [3:0] cnt;
    logic qual;
    logic flag;
    logic req;
  } pin_state_t;

  // State of the mode controller
  typedef struct packed {
    pmode_t mode;
    logic [1:0] power_control_reg;
    logic cmode;
    logic woke;
    logic [2:0] rst_cnt;
    logic sys_reset;
    logic pc_load;
    logic resume_next;
    logic core_en;
    logic periph_en;
    logic adc_en;
    logic main_gate;
    logic slow_gate;
    logic [1:0] sw_cnt;
    logic adc_s1;
    logic adc_s2;
    logic rr_s1;
    logic rr_s2;
    logic mo_s1;
    logic mo_s2;
    logic mo_s3;
    logic so_s1;
    logic so_s2;
    logic so_s3;
  } ctl_state_t;

endpackage

// file: core/ext_pin_qual.sv
`timescale 1ns/1ps
module ext_pin_qual import pwr_mode_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin_b,
  input wire logic edge_mode,
  input wire logic ack,
  output logic req_r
);

  pin_state_t s_r;
  pin_state_t s_nxt;

  // Sync first, then count active clocks, then level or edge
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin_b;
    s_nxt.s2 = s_r.s1;
    if (s_r.s2) begin
      s_nxt.cnt = 4'h0;
    end else if (s_r.cnt != QUAL_LEN) begin
      s_nxt.cnt = s_r.cnt + 4'h1;
    end
    s_nxt.qual = (s_nxt.cnt == QUAL_LEN);
    // Set beats ack so a new edge is never lost
    if (s_nxt.qual && !s_r.qual) begin
      s_nxt.flag = 1'b1;
    end else if (ack) begin
      s_nxt.flag = 1'b0;
    end
    s_nxt.req = edge_mode ? s_nxt.flag : s_nxt.qual;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      // Syncs start at the pulled-up idle level, so no false activity
      s_r.s1 <= 1'b1;
      s_r.s2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_r = s_r.req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  pulse_qual_a: assert property ((!s_r.s2) [*8] |=> s_r.qual)
    else $error("Pin held active 8 clocks not qualified");
  edge_set_a: assert property ($rose(s_r.qual) && edge_mode |-> req_r)
    else $error("Edge request missing after qualified edge");

endmodule

// file: core/power_mode_wake_control.sv
`timescale 1ns/1ps
// What this block does
// - Idle stops core after instruction, peripherals run
// - Enabled interrupt clears idle bit and wakes
// - Return-from-interrupt resumes after idle instruction
// - Reset in low power resets, restarts 0x0000
// - Stop gates core and peripheral clocks, ADC not
// - ADC threshold raises reset during power-down
// - Stop bit leaves oscillators untouched
// - Only reset ends power-down, never interrupts
// - Two external pins, per-pin level/edge select
// - Enabled pin pulse over 8 clocks recognised
// - Pins wake idle but not power-down
// - Mode bit selects main or slow oscillator
// - Power reg bit0 idle, bit1 stop, reset 0
// - Glitch-free switch within 2-3 new periods
// - Clock mode bit 0, resets to main
module power_mode_wake_control import pwr_mode_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire core_req_t core_req,
  input wire ext_cfg_t ext_cfg,
  input wire logic [1:0] ext_irq_pin_b,
  input wire logic adc_over_threshold,
  input wire logic reset_request,
  input wire logic main_osc_lvl,
  input wire logic slow_osc_lvl,
  output logic idle_select_bit_r,
  output logic stop_select_bit_r,
  output logic clock_mode_select_r,
  output logic core_clk_en_r,
  output logic periph_clk_en_r,
  output logic adc_clk_en_r,
  output logic main_clk_gate_r,
  output logic slow_clk_gate_r,
  output logic sys_reset_r,
  output logic pc_load_r,
  output logic [15:0] pc_value_r,
  output logic resume_next_r,
  output logic [1:0] ext_irq_req_r
);

  ctl_state_t s_r;
  ctl_state_t s_nxt;
  logic [1:0] pin_req;
  logic wake_irq;
  logic ext_wake;
  logic rst_cond;
  logic mo_rise;
  logic mo_fall;
  logic so_rise;
  logic so_fall;

  // One qualifier per external interrupt pin
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      ext_pin_qual u_qual (
        .clk(clk),
        .rst_b(rst_b),
        .pin_b(ext_irq_pin_b[g]),
        .edge_mode(ext_cfg.trigger_type[g]),
        .ack(ext_cfg.irq_ack[g]),
        .req_r(pin_req[g])
      );
    end
  endgenerate

  // Wake and reset causes
  assign ext_wake = ext_cfg.global_enable &&
                    |(pin_req & ext_cfg.irq_enable);
  assign wake_irq = ext_wake || core_req.periph_irq;
  assign rst_cond = s_r.rr_s2 ||
                    (s_r.mode == MODE_STOP && s_r.adc_s2);
  assign mo_rise = s_r.mo_s2 && !s_r.mo_s3;
  assign mo_fall = !s_r.mo_s2 && s_r.mo_s3;
  assign so_rise = s_r.so_s2 && !s_r.so_s3;
  assign so_fall = !s_r.so_s2 && s_r.so_s3;

  always_comb begin
    s_nxt = s_r;
    s_nxt.pc_load = 1'b0;
    s_nxt.resume_next = 1'b0;
    s_nxt.adc_en = 1'b1;
    // Two-flop syncs for inputs from other domains
    s_nxt.adc_s1 = adc_over_threshold;
    s_nxt.adc_s2 = s_r.adc_s1;
    s_nxt.rr_s1 = reset_request;
    s_nxt.rr_s2 = s_r.rr_s1;
    s_nxt.mo_s1 = main_osc_lvl;
    s_nxt.mo_s2 = s_r.mo_s1;
    s_nxt.mo_s3 = s_r.mo_s2;
    s_nxt.so_s1 = slow_osc_lvl;
    s_nxt.so_s2 = s_r.so_s1;
    s_nxt.so_s3 = s_r.so_s2;

    // Register writes from the core
    if (core_req.power_control_reg_wr) begin
      s_nxt.power_control_reg = core_req.power_control_reg_wdata;
    end
    if (core_req.xcon_wr) begin
      s_nxt.cmode = core_req.xcon_wdata;
    end
    if (core_req.return_from_interrupt && s_r.woke) begin
      s_nxt.resume_next = 1'b1;
      s_nxt.woke = 1'b0;
    end

    // Mode sequencing; oscillator gates are left to the switch below
    case (s_r.mode)
      MODE_ACTIVE: begin
        s_nxt.core_en = 1'b1;
        s_nxt.periph_en = 1'b1;
        if (rst_cond) begin
          s_nxt.mode = MODE_RESET;
        end else if (core_req.inst_done && s_nxt.power_control_reg[STOP_POS]) begin
          s_nxt.mode = MODE_STOP;
          s_nxt.core_en = 1'b0;
          s_nxt.periph_en = 1'b0;
        end else if (core_req.inst_done && s_nxt.power_control_reg[IDLE_POS]) begin
          s_nxt.mode = MODE_IDLE;
          s_nxt.core_en = 1'b0;
        end
      end
      MODE_IDLE: begin
        if (rst_cond) begin
          s_nxt.mode = MODE_RESET;
        end else if (wake_irq) begin
          s_nxt.mode = MODE_ACTIVE;
          s_nxt.power_control_reg[IDLE_POS] = 1'b0;
          s_nxt.core_en = 1'b1;
          s_nxt.woke = 1'b1;
        end
      end
      MODE_STOP: begin
        // Interrupts and pins are ignored here on purpose
        if (rst_cond) begin
          s_nxt.mode = MODE_RESET;
        end
      end
      MODE_RESET: begin
        s_nxt.core_en = 1'b0;
        s_nxt.periph_en = 1'b0;
        s_nxt.power_control_reg = POWER_CONTROL_REG_RESET;
        s_nxt.cmode = CMODE_RESET;
        s_nxt.woke = 1'b0;
        if (rst_cond) begin
          s_nxt.rst_cnt = 3'h0;
        end else if (s_r.rst_cnt != RESET_HOLD) begin
          s_nxt.rst_cnt = s_r.rst_cnt + 3'h1;
        end else begin
          s_nxt.mode = MODE_ACTIVE;
          s_nxt.pc_load = 1'b1;
          s_nxt.rst_cnt = 3'h0;
        end
      end
      default: begin
        s_nxt.mode = MODE_RESET;
      end
    endcase
    s_nxt.sys_reset = (s_nxt.mode == MODE_RESET);

    // Break-before-make switch: old gate drops on its low phase,
    // new gate opens after two new rising edges
    if (s_r.cmode) begin
      if (s_r.main_gate) begin
        if (mo_fall) begin
          s_nxt.main_gate = 1'b0;
          s_nxt.sw_cnt = 2'h0;
        end
      end else if (!s_r.slow_gate && so_rise) begin
        s_nxt.sw_cnt = s_r.sw_cnt + 2'h1;
        s_nxt.slow_gate = (s_nxt.sw_cnt == SWITCH_EDGES);
      end
    end else begin
      if (s_r.slow_gate) begin
        if (so_fall) begin
          s_nxt.slow_gate = 1'b0;
          s_nxt.sw_cnt = 2'h0;
        end
      end else if (!s_r.main_gate && mo_rise) begin
        s_nxt.sw_cnt = s_r.sw_cnt + 2'h1;
        s_nxt.main_gate = (s_nxt.sw_cnt == SWITCH_EDGES);
      end
    end
    // A reversed switch must count its own two edges afresh
    if (s_nxt.cmode != s_r.cmode) begin
      s_nxt.sw_cnt = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.mode <= MODE_ACTIVE;
      s_r.core_en <= 1'b1;
      s_r.periph_en <= 1'b1;
      s_r.adc_en <= 1'b1;
      s_r.main_gate <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Ext requests registered toward the core
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_irq_req_r <= 2'h0;
    end else begin
      ext_irq_req_r <= pin_req;
    end
  end

  assign idle_select_bit_r = s_r.power_control_reg[IDLE_POS];
  assign stop_select_bit_r = s_r.power_control_reg[STOP_POS];
  assign clock_mode_select_r = s_r.cmode;
  assign core_clk_en_r = s_r.core_en;
  assign periph_clk_en_r = s_r.periph_en;
  assign adc_clk_en_r = s_r.adc_en;
  assign main_clk_gate_r = s_r.main_gate;
  assign slow_clk_gate_r = s_r.slow_gate;
  assign sys_reset_r = s_r.sys_reset;
  assign pc_load_r = s_r.pc_load;
  assign pc_value_r = RESET_VECTOR;
  assign resume_next_r = s_r.resume_next;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence idle_req_s;
    s_r.mode == MODE_ACTIVE && !rst_cond && core_req.inst_done &&
    s_nxt.power_control_reg == 2'h1;
  endsequence

  idle_entry_a: assert property (idle_req_s |=>
      s_r.mode == MODE_IDLE && !core_clk_en_r && periph_clk_en_r)
    else $error("Idle not entered with peripherals running");
  idle_wake_a: assert property (s_r.mode == MODE_IDLE && !rst_cond &&
      wake_irq |=> !idle_select_bit_r && core_clk_en_r)
    else $error("Idle not left on enabled interrupt");
  resume_a: assert property (core_req.return_from_interrupt && s_r.woke |=>
      resume_next_r ##1 !resume_next_r)
    else $error("Resume pulse missing after return");
  restart_a: assert property ($fell(sys_reset_r) |->
      pc_load_r && pc_value_r == 16'h0000 && !idle_select_bit_r)
    else $error("Restart not at address zero");
  stop_gate_a: assert property (s_r.mode == MODE_STOP |->
      !core_clk_en_r && !periph_clk_en_r && adc_clk_en_r)
    else $error("Clock trees wrong in power-down");
  adc_reset_a: assert property (s_r.mode == MODE_STOP &&
      s_r.adc_s2 |=> sys_reset_r [*5])
    else $error("ADC threshold did not reset");
  stop_hold_a: assert property (s_r.mode == MODE_STOP &&
      !rst_cond |=> s_r.mode == MODE_STOP)
    else $error("Power-down left without reset");
  no_overlap_a: assert property (!(main_clk_gate_r &&
      slow_clk_gate_r))
    else $error("Both oscillator gates open");

endmodule

// file: tb/core_pin_model.sv
`timescale 1ns/1ps
module core_pin_model (
  input wire logic clk,
  output logic main_osc_lvl,
  output logic slow_osc_lvl,
  output logic [1:0] ext_irq_pin_b
);
  // Main crystal, range already set by software
  initial begin
    main_osc_lvl = 1'b0;
    forever #30 main_osc_lvl = ~main_osc_lvl;
  end
  // Slow osc scaled up so a switch fits a short run
  initial begin
    slow_osc_lvl = 1'b0;
    forever #70 slow_osc_lvl = ~slow_osc_lvl;
  end
  // Pins idle high under their pull-ups
  initial ext_irq_pin_b = 2'h3;
  // Hold one pin low for n clocks, released just after an edge
  task automatic pin_pulse(input int idx, input int n);
    ext_irq_pin_b[idx] = 1'b0;
    repeat (n) @(posedge clk);
    #1 ext_irq_pin_b[idx] = 1'b1;
  endtask
endmodule

// file: tb/power_mode_wake_control_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      err_count++; \
      $display("Error %s exp %h got %h", nm, ex, got); \
    end \
  end
`define WAITC(c, lim) for (k = 0; k < (lim) && !(c); k++) tick(1);
module power_mode_wake_control_bench import pwr_mode_pkg::*;;
  logic clk, rst_b, adc_thr, rst_req, mosc, sosc;
  logic [1:0] pins_b, req_q;
  core_req_t creq;
  ext_cfg_t cfg;
  logic idle_q, stop_q, cm_q, core_q, per_q, adc_q, mg_q, sg_q;
  logic rst_q, pcl_q, res_q;
  logic [15:0] pcv_q;
  logic [1:0] m_power_control_reg;
  logic m_cm;
  int err_count, n_checks, seed, cyc, i, k;

  power_mode_wake_control power_mode_wake_control_inst (
    .clk(clk), .rst_b(rst_b), .core_req(creq), .ext_cfg(cfg),
    .ext_irq_pin_b(pins_b), .adc_over_threshold(adc_thr),
    .reset_request(rst_req), .main_osc_lvl(mosc), .slow_osc_lvl(sosc),
    .idle_select_bit_r(idle_q), .stop_select_bit_r(stop_q),
    .clock_mode_select_r(cm_q), .core_clk_en_r(core_q),
    .periph_clk_en_r(per_q), .adc_clk_en_r(adc_q),
    .main_clk_gate_r(mg_q), .slow_clk_gate_r(sg_q),
    .sys_reset_r(rst_q), .pc_load_r(pcl_q), .pc_value_r(pcv_q),
    .resume_next_r(res_q), .ext_irq_req_r(req_q)
  );
  core_pin_model core_pin_model_inst (
    .clk(clk), .main_osc_lvl(mosc), .slow_osc_lvl(sosc),
    .ext_irq_pin_b(pins_b)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  // Drives land 1 ns after the edge, never racing it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic power_control_reg(input logic [1:0] d, input logic go);
    creq.power_control_reg_wr = 1'b1;
    creq.power_control_reg_wdata = d;
    creq.inst_done = go;
    tick(1);
    creq.power_control_reg_wr = 1'b0;
    creq.inst_done = 1'b0;
    m_power_control_reg = d;
    // Let an edge pass so a next call never re-raises in this step
    tick(1);
  endtask
  task automatic xcon(input logic d);
    creq.xcon_wr = 1'b1;
    creq.xcon_wdata = d;
    tick(1);
    creq.xcon_wr = 1'b0;
    m_cm = d;
  endtask
  task automatic cmp_regs();
    `CHK("idle", m_power_control_reg[0], idle_q)
    `CHK("stop", m_power_control_reg[1], stop_q)
    `CHK("cmode", m_cm, cm_q)
  endtask
  // Reset release: restart pulse at address zero
  task automatic rst_release();
    `WAITC(pcl_q === 1'b1, 30)
    `CHK("pc_load", 1'b1, pcl_q)
    `CHK("pc_value", 16'h0000, pcv_q)
    `CHK("sys_reset", 1'b0, rst_q)
    tick(1);
    `CHK("pc_load", 1'b0, pcl_q)
    `CHK("core", 1'b1, core_q)
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    seed = 32'ha475;
    creq = '0;
    cfg = '0;
    rst_b = 1'b0;
    adc_thr = 1'b0;
    rst_req = 1'b0;
    m_power_control_reg = 2'h0;
    m_cm = 1'b0;
    tick(10);
    rst_b = 1'b1;
    tick(1);
    cmp_regs();
    `CHK("main_gate", 1'b1, mg_q)
    `CHK("slow_gate", 1'b0, sg_q)
    // Random writes without a completing instruction
    for (i = 0; i < 6; i++) begin
      power_control_reg(2'($random(seed)), 1'b0);
      cmp_regs();
    end
    power_control_reg(2'h0, 1'b0);
    $display("test register writes done");
    // Idle, woken by a peripheral, then return
    power_control_reg(2'h1, 1'b1);
    `CHK("core", 1'b0, core_q)
    `CHK("periph", 1'b1, per_q)
    tick(3);
    creq.periph_irq = 1'b1;
    tick(1);
    creq.periph_irq = 1'b0;
    m_power_control_reg = 2'h0;
    cmp_regs();
    `CHK("core", 1'b1, core_q)
    creq.return_from_interrupt = 1'b1;
    tick(1);
    creq.return_from_interrupt = 1'b0;
    `CHK("resume", 1'b1, res_q)
    tick(1);
    `CHK("resume", 1'b0, res_q)
    $display("test idle wake done");
    // Pin 0 level, pin 1 edge; each wakes idle
    cfg.global_enable = 1'b1;
    cfg.irq_enable = 2'h3;
    cfg.trigger_type = 2'h2;
    for (i = 0; i < 2; i++) begin
      power_control_reg(2'h1, 1'b1);
      core_pin_model_inst.pin_pulse(i, 9 + ($random(seed) & 1));
      `CHK("early", 1'b0, core_q)
      `WAITC(core_q === 1'b1, 20)
      m_power_control_reg = 2'h0;
      `CHK("core", 1'b1, core_q)
      cmp_regs();
      tick(4);
      `CHK("pin_req", i == 1, req_q[i])
    end
    cfg.irq_ack = 2'h2;
    tick(1);
    cfg.irq_ack = 2'h0;
    tick(2);
    `CHK("pin_req", 1'b0, req_q[1])
    $display("test pin wake done");
    // Both bits set: stop wins; power-down ignores irqs; ADC resets
    power_control_reg(2'h3, 1'b1);
    `CHK("core", 1'b0, core_q)
    `CHK("periph", 1'b0, per_q)
    `CHK("adc", 1'b1, adc_q)
    creq.periph_irq = 1'b1;
    core_pin_model_inst.pin_pulse(0, 12);
    tick(6);
    creq.periph_irq = 1'b0;
    `CHK("core", 1'b0, core_q)
    cmp_regs();
    `CHK("main_gate", 1'b1, mg_q)
    adc_thr = 1'b1;
    `WAITC(rst_q === 1'b1, 8)
    `CHK("sys_reset", 1'b1, rst_q)
    m_power_control_reg = 2'h0;
    tick(1);
    cmp_regs();
    adc_thr = 1'b0;
    rst_release();
    $display("test power-down done");
    // Switch to slow oscillator and back
    for (i = 0; i < 2; i++) begin
      xcon(~i[0]);
      cmp_regs();
      for (k = 0; k < 80 && (m_cm ? sg_q : mg_q) !== 1'b1; k++) begin
        `CHK("overlap", 1'b0, mg_q & sg_q)
        tick(1);
      end
      `CHK("slow_gate", m_cm, sg_q)
      `CHK("main_gate", ~m_cm, mg_q)
      `CHK("in_time", 1'b1, k <= (m_cm ? 52 : 36))
    end
    $display("test clock switch done");
    // Reset request in idle clears every bit
    xcon(1'b1);
    power_control_reg(2'h1, 1'b1);
    rst_req = 1'b1;
    `WAITC(rst_q === 1'b1, 8)
    m_power_control_reg = 2'h0;
    m_cm = 1'b0;
    tick(1);
    cmp_regs();
    rst_req = 1'b0;
    rst_release();
    $display("test idle reset done");
    results();
  end
endmodule
